// File: src/sdwt_pkg.sv
package sdwt_pkg;
    // Clock rates: the local clock, the controller reference and the memory clock.
    localparam int SYS_CLK_HZ = 200_000_000;
    localparam int REF_CLK_HZ = 50_000_000;
    localparam int MEM_CLK_HZ = 100_000_000;
    localparam int REF_DIV = SYS_CLK_HZ / REF_CLK_HZ;
    localparam int MEM_DIV = SYS_CLK_HZ / MEM_CLK_HZ;

    // Memory geometry: 64 megabytes seen as 16-bit words.
    localparam int MEM_MBYTES = 64;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 25;
    localparam int MEM_WORDS = MEM_MBYTES * 1024 * 1024 / (DATA_W / 8);

    // Pass budget and blink timing.
    localparam int TEST_TIME_S = 8;
    localparam longint TIMEOUT_CYC = longint'(TEST_TIME_S) * longint'(SYS_CLK_HZ);
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_TICKS = REF_CLK_HZ / 1000 * BLINK_HALF_MS;

    // Pattern generator seed and polynomial taps.
    localparam logic [15:0] PAT_SEED = 16'hACE1;
    localparam logic [15:0] PAT_TAPS = 16'hB400;

    // LED values.
    localparam logic [2:0] LEDS_ALL = 3'h7;
    localparam logic [2:0] LEDS_OFF = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_WRITE,
        ST_READ,
        ST_DONE
    } sdwt_state_type;
endpackage : sdwt_pkg

// File: src/sdwt_pat_if.sv
`timescale 1ns/1ps
// Carries the pattern generator's controls and its current word.
interface sdwt_pat_if;
    logic restart;
    logic advance;
    logic [15:0] value;
    modport gen (input restart, input advance, output value);
    modport user (output restart, output advance, input value);
endinterface : sdwt_pat_if

// File: src/sdwt_pattern.sv
`timescale 1ns/1ps
module sdwt_pattern
    import sdwt_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic nrst,    // Asynchronous reset, active low.
    sdwt_pat_if.gen pat       // Restart, advance and current word.
);
    // Galois shift register; a restart always wins so both phases see the same sequence.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pat.value <= PAT_SEED;
        end else if (pat.restart) begin
            pat.value <= PAT_SEED;
        end else if (pat.advance) begin
            pat.value <= pat.value[0] ? ((pat.value >> 1) ^ PAT_TAPS) : (pat.value >> 1);
        end
    end
endmodule : sdwt_pattern

// File: src/sdwt_tester.sv
`timescale 1ns/1ps
// Functional notes
// - Write the whole memory with a sequence, then read back and compare regenerated.
// - Covered addresses span the full 64 megabyte memory.
// - Controller gets 50 MHz reference and 100 MHz memory rate enables, both derived here from the local clock.
// - Only the start button launches a test run toward the memory.
// - Button held lights three LEDs; after release pass and heartbeat LEDs blink.
// - All words match after release: pass LED stops blinking, stays on.
// - Pass should finish in about eight seconds, else the run is failed.
// - Heartbeat LED blinks from a divider of the 50 MHz reference.
// - Pressing start again restarts the sequence and clears the old result.
module sdwt_tester
    import sdwt_pkg::*;
#(
    parameter int unsigned WORDS = MEM_WORDS,            // Words tested.
    parameter longint unsigned TIMEOUT_CYCLES = TIMEOUT_CYC, // Run budget.
    parameter int unsigned BLINK_TICKS = BLINK_HALF_TICKS   // Reference ticks per blink half.
)
(
    input wire logic sys_clk,                 // 200 MHz clock.
    input wire logic nrst,                    // Asynchronous reset, active low.
    input wire logic start_button_n,          // Start push-button, low when pressed.
    output logic ref_tick,                    // 50 MHz enable toward the controller.
    output logic mem_tick,                    // 100 MHz enable toward the controller.
    output logic cmd_valid,                   // Access request.
    output logic cmd_write,                   // High for write, low for read.
    output logic [ADDR_W-1:0] cmd_addr,       // Word address.
    output logic [DATA_W-1:0] cmd_wdata,      // Write data.
    input wire logic cmd_ready,               // Controller takes the request.
    input wire logic rd_valid,                // Read data returned.
    input wire logic [DATA_W-1:0] rd_data,    // Read data, in request order.
    output logic [2:0] status_leds            // Done-fail, pass and heartbeat LEDs.
);
    sdwt_state_type state_r;
    logic btn_r;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] cmp_r;
    logic rd_all_r;
    logic fail_r;
    logic [63:0] run_cnt_r;
    logic [1:0] ref_cnt_r;
    logic mem_cnt_r;
    logic [23:0] hb_cnt_r;
    logic hb_r;
    logic accept;
    logic running;
    logic start;
    logic timeout;
    logic last_wr;
    logic last_cmp;
    logic mismatch;
    sdwt_pat_if pat ();

    // Compares a word counter with the last word of the range.
    function automatic logic is_last(input logic [ADDR_W-1:0] a);
        return a == ADDR_W'(WORDS - 1);
    endfunction : is_last

    sdwt_pattern u_pattern (
        .sys_clk (sys_clk),
        .nrst (nrst),
        .pat (pat)
    );

    // Request and event decode; the handshake is combinational so no cycle is lost.
    assign running = (state_r == ST_WRITE) || (state_r == ST_READ);
    assign start = (state_r == ST_HOLD) && !btn_r;
    assign cmd_valid = (state_r == ST_WRITE) || ((state_r == ST_READ) && !rd_all_r);
    assign cmd_write = (state_r == ST_WRITE);
    assign cmd_addr = addr_r;
    assign cmd_wdata = pat.value;
    assign accept = cmd_valid && cmd_ready;
    assign last_wr = (state_r == ST_WRITE) && accept && is_last(addr_r);
    assign last_cmp = (state_r == ST_READ) && rd_valid && is_last(cmp_r);
    assign mismatch = (state_r == ST_READ) && rd_valid && (rd_data != pat.value);
    assign timeout = running && (run_cnt_r == 64'(TIMEOUT_CYCLES - 1));

    // Reseeding at the start and again before the read phase regenerates the same words.
    assign pat.restart = start || last_wr;
    assign pat.advance = (cmd_write && accept) || ((state_r == ST_READ) && rd_valid);

    // Button sample; the pin is taken as synchronous to the clock.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            btn_r <= 1'b0;
        end else begin
            btn_r <= !start_button_n;
        end
    end

    // Run sequencing: a press always aborts and holds, release starts over.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else if (btn_r) begin
            state_r <= ST_HOLD;
        end else begin
            case (state_r)
                ST_HOLD: begin
                    state_r <= ST_WRITE;
                end
                ST_WRITE: begin
                    if (timeout) begin
                        state_r <= ST_DONE;
                    end else if (last_wr) begin
                        state_r <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (timeout || last_cmp) begin
                        state_r <= ST_DONE;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Issue address; reused for reads after the write phase wraps it to zero.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            addr_r <= '0;
            rd_all_r <= 1'b0;
        end else if (start) begin
            addr_r <= '0;
            rd_all_r <= 1'b0;
        end else if (accept) begin
            addr_r <= is_last(addr_r) ? '0 : addr_r + 1'b1;
            if (!cmd_write && is_last(addr_r)) begin
                rd_all_r <= 1'b1;
            end
        end
    end

    // Compare counter follows returned words, which may lag the requests.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cmp_r <= '0;
        end else if (start) begin
            cmp_r <= '0;
        end else if ((state_r == ST_READ) && rd_valid) begin
            cmp_r <= cmp_r + 1'b1;
        end
    end

    // Failure flag: only a new run clears it, and no mismatch occurs in the hold state.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fail_r <= 1'b0;
        end else if (mismatch || timeout) begin
            fail_r <= 1'b1;
        end else if (start) begin
            fail_r <= 1'b0;
        end
    end

    // Run time budget counter.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            run_cnt_r <= '0;
        end else if (start) begin
            run_cnt_r <= '0;
        end else if (running) begin
            run_cnt_r <= run_cnt_r + 1'b1;
        end
    end

    // Reference and memory rate enables derived from the local clock.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ref_cnt_r <= '0;
            mem_cnt_r <= 1'b0;
        end else begin
            ref_cnt_r <= (ref_cnt_r == 2'(REF_DIV - 1)) ? '0 : ref_cnt_r + 1'b1;
            mem_cnt_r <= (MEM_DIV == 2) ? !mem_cnt_r : 1'b0;
        end
    end
    assign ref_tick = (ref_cnt_r == 2'(REF_DIV - 1));
    assign mem_tick = mem_cnt_r;

    // Heartbeat toggles from the reference rate, so it stops if that rate stops.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            hb_cnt_r <= '0;
            hb_r <= 1'b0;
        end else if (ref_tick) begin
            if (hb_cnt_r == 24'(BLINK_TICKS - 1)) begin
                hb_cnt_r <= '0;
                hb_r <= !hb_r;
            end else begin
                hb_cnt_r <= hb_cnt_r + 1'b1;
            end
        end
    end

    // LED drive: bit 0 reports a failed run, bit 1 is pass, bit 2 is heartbeat.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_leds <= LEDS_OFF;
        end else if (state_r == ST_HOLD) begin
            status_leds <= LEDS_ALL;
        end else begin
            status_leds[2] <= hb_r;
            status_leds[1] <= running ? hb_r : ((state_r == ST_DONE) && !fail_r);
            status_leds[0] <= (state_r == ST_DONE) && fail_r;
        end
    end

    property p_read_after_write;
        @(posedge sys_clk) disable iff (!nrst)
        (cmd_valid && !cmd_write) |-> (state_r == ST_READ) && $past(state_r != ST_HOLD);
    endproperty
    a_read_after_write: assert property (p_read_after_write) else $error("read before write end");

    property p_span;
        @(posedge sys_clk) disable iff (!nrst)
        (last_wr && !timeout && !btn_r) |=> (state_r == ST_READ) && (addr_r == '0);
    endproperty
    a_span: assert property (p_span) else $error("write phase did not end at last word");

    property p_ref_rate;
        @(posedge sys_clk) disable iff (!nrst)
        ref_tick |=> !ref_tick [*3] ##1 ref_tick;
    endproperty
    a_ref_rate: assert property (p_ref_rate) else $error("reference enable not one in four");

    property p_no_self_start;
        @(posedge sys_clk) disable iff (!nrst)
        ((state_r == ST_IDLE) || (state_r == ST_DONE)) && !btn_r |=> !running;
    endproperty
    a_no_self_start: assert property (p_no_self_start) else $error("run began without button");

    property p_hold_leds;
        @(posedge sys_clk) disable iff (!nrst)
        btn_r ##1 btn_r |=> (status_leds == LEDS_ALL);
    endproperty
    a_hold_leds: assert property (p_hold_leds) else $error("LEDs not all on while held");

    property p_pass_steady;
        @(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_DONE) && !fail_r && !btn_r |=> status_leds[1] && !status_leds[0];
    endproperty
    a_pass_steady: assert property (p_pass_steady) else $error("pass LED not steady");

    property p_timeout;
        @(posedge sys_clk) disable iff (!nrst)
        timeout && !btn_r |=> (state_r == ST_DONE) && fail_r;
    endproperty
    a_timeout: assert property (p_timeout) else $error("overrun not failed");

    property p_restart;
        @(posedge sys_clk) disable iff (!nrst)
        start |=> (state_r == ST_WRITE) && !fail_r && (addr_r == '0) && (run_cnt_r == '0);
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear run");

    property p_fail_latch;
        @(posedge sys_clk) disable iff (!nrst)
        fail_r && !start |=> fail_r;
    endproperty
    a_fail_latch: assert property (p_fail_latch) else $error("failure lost");

    property p_heartbeat;
        @(posedge sys_clk) disable iff (!nrst)
        !ref_tick |=> $stable(hb_r);
    endproperty
    a_heartbeat: assert property (p_heartbeat) else $error("heartbeat moved off reference");
endmodule : sdwt_tester

// File: bench/sdwt_mem_model.sv
`timescale 1ns/1ps
// Behavioural controller and memory that answer the tester's access requests.
module sdwt_mem_model
    import sdwt_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic cmd_valid, // Access request.
    input wire logic cmd_write, // High for write.
    input wire logic [ADDR_W-1:0] cmd_addr, // Word address.
    input wire logic [DATA_W-1:0] cmd_wdata, // Write data.
    output logic cmd_ready, // Request taken.
    output logic rd_valid, // Read word returned.
    output logic [DATA_W-1:0] rd_data, // Read word.
    input wire logic [1:0] pace, // 0 prompt, 1 alternate cycles, 2 never ready.
    input wire logic bad_en, // Corrupt one read word.
    input wire logic [ADDR_W-1:0] bad_addr // Address of the corrupted word.
);
    logic [DATA_W-1:0] mem [int];
    logic phase_r;

    // Slow pacing only accepts on alternate cycles, a stalled controller never does.
    assign cmd_ready = (pace == 2'h0) || ((pace == 2'h1) && phase_r);

    // Writes are stored, reads answered one cycle later in request order.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            phase_r <= ~phase_r;
            if (cmd_valid && cmd_ready && cmd_write) begin
                mem[int'(cmd_addr)] = cmd_wdata;
            end
            if (cmd_valid && cmd_ready && !cmd_write) begin
                rd_valid <= 1'b1;
                rd_data <= mem[int'(cmd_addr)] ^ {15'h0000, bad_en && (cmd_addr == bad_addr)};
            end else begin
                rd_valid <= 1'b0;
                // The data lines change between words so no stale word looks valid.
                rd_data <= ~rd_data;
            end
        end
    end
endmodule : sdwt_mem_model

// File: bench/sdwt_tester_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the memory write-and-verify tester.
module sdwt_tester_tb;
    import sdwt_pkg::*;
    localparam int N = 16;
    localparam int TMO = 2000;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic start_button_n = 1'b1;
    logic [1:0] pace = 2'h0;
    logic bad_en = 1'b0;
    logic [ADDR_W-1:0] bad_addr = '0;
    logic ref_tick, mem_tick, cmd_valid, cmd_write, cmd_ready, rd_valid;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_wdata, rd_data;
    logic [2:0] status_leds;
    logic hb_prev = 1'b0;
    logic [15:0] wr_pat;
    int num_errors = 0;
    int num_checks = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int hb_cnt = 0;

    always #2.5 sys_clk = ~sys_clk;

    sdwt_tester #(.WORDS(N), .TIMEOUT_CYCLES(TMO), .BLINK_TICKS(4)) dut (.sys_clk(sys_clk),
        .nrst(nrst), .start_button_n(start_button_n), .ref_tick(ref_tick), .mem_tick(mem_tick),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .status_leds(status_leds));
    sdwt_mem_model mem (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .pace(pace), .bad_en(bad_en), .bad_addr(bad_addr));

    // Compares one observed value with its expectation.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
        end
    endtask : chk

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (num_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Accepted requests are judged at the falling edge, where everything has settled.
    always @(negedge sys_clk) begin
        if (status_leds[2] !== hb_prev) hb_cnt++;
        hb_prev = status_leds[2];
        if (nrst && cmd_valid && cmd_ready && cmd_write) begin
            chk("write address", 32'(cmd_addr), wr_cnt);
            chk("write data", 32'(cmd_wdata), 32'(wr_pat));
            wr_cnt++;
            wr_pat = wr_pat[0] ? ((wr_pat >> 1) ^ PAT_TAPS) : (wr_pat >> 1);
        end else if (nrst && cmd_valid && cmd_ready) begin
            chk("writes before read", wr_cnt, N);
            chk("read address", 32'(cmd_addr), rd_cnt);
            rd_cnt++;
        end
    end

    // Presses and releases the button; all three LEDs must light while it is held.
    // Counters restart only once the press has stopped any earlier run.
    task automatic start_run();
        start_button_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1 chk("leds while held", 32'(status_leds), 32'(LEDS_ALL));
        wr_cnt = 0;
        rd_cnt = 0;
        wr_pat = PAT_SEED;
        start_button_n = 1'b1;
        hb_cnt = 0;
    endtask : start_run

    // Waits for every read to be issued, then looks at the settled LEDs for a while.
    task automatic finish_run(input logic [1:0] leds_exp);
        for (int i = 0; i < 400 && rd_cnt < N; i++) @(posedge sys_clk);
        chk("words read", rd_cnt, N);
        chk("words written", wr_cnt, N);
        repeat (40) @(posedge sys_clk);
        chk("heartbeat toggles seen", 32'(hb_cnt > 2), 1);
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            chk("result leds", 32'(status_leds[1:0]), 32'(leds_exp));
        end
    endtask : finish_run

    // Idle after reset: nothing issued without the button, rate enables run.
    task automatic t_idle();
        int refs;
        int mems;
        refs = 0;
        mems = 0;
        chk("leds at reset", 32'(status_leds), 32'(LEDS_OFF));
        chk("wdata at reset", 32'(cmd_wdata), 32'(PAT_SEED));
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            refs += int'(ref_tick);
            mems += int'(mem_tick);
            chk("idle request", 32'(cmd_valid), 0);
        end
        chk("ref ticks in 40", refs, 40 / REF_DIV);
        chk("mem ticks in 40", mems, 40 / MEM_DIV);
    endtask : t_idle

    // A run through a prompt or slow controller ends with a steady pass LED.
    task automatic t_pass(input logic [1:0] p);
        @(posedge sys_clk);
        #1 pace = p;
        start_run();
        finish_run(2'h2);
    endtask : t_pass

    // One bad word latches the failure for the whole run.
    task automatic t_fail();
        @(posedge sys_clk);
        #1 bad_en = 1'b1;
        bad_addr = 25'h0000005;
        start_run();
        finish_run(2'h1);
        @(posedge sys_clk);
        #1 bad_en = 1'b0;
    endtask : t_fail

    // A press in mid-write aborts the run, and the next release starts over from word zero.
    task automatic t_abort();
        @(posedge sys_clk);
        #1 pace = 2'h1;
        start_run();
        repeat (20) @(posedge sys_clk);
        chk("writes before abort", 32'(wr_cnt > 0 && wr_cnt < N), 1);
        #1 start_run();
        finish_run(2'h2);
    endtask : t_abort

    // A controller that never accepts makes the run fail at the time budget.
    task automatic t_timeout();
        @(posedge sys_clk);
        #1 pace = 2'h2;
        start_run();
        repeat (TMO + 50) @(posedge sys_clk);
        chk("timeout leds", 32'(status_leds[1:0]), 32'h1);
        chk("writes while stalled", wr_cnt, 0);
        #1 pace = 2'h0;
    endtask : t_timeout

    // Hang guard, far beyond the expected few thousand cycles.
    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 nrst = 1'b1;
        t_idle();
        t_pass(2'h0);
        t_fail();
        t_pass(2'h1);
        t_abort();
        t_timeout();
        t_pass(2'h0);
        final_report();
    end
endmodule : sdwt_tester_tb
